//--- hdl/op_pkg.sv
// Constants for the call, clear, invert and decrement execution block.
// Assumes a fetch stage that hands over one decoded operation per request.
package op_pkg;
	localparam int PC_W = 15;
	localparam int IMM_W = 11;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int LATCH_W = 7;
	localparam int LATCH_HI = 6;
	localparam int LATCH_LO = 3;
	localparam int CALL_CYCLES = 2;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
	localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
	localparam logic DEST_ACC = 1'b0;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_DIRECT_CALL,
		OP_INDIRECT_SUBROUTINE_JUMP,
		OP_WATCHDOG_KICK,
		OP_INVERT_FILE_REG,
		OP_FILE_DECREMENT,
		OP_ZERO_FILE_REG,
		OP_ZERO_ACCUMULATOR
	} op_e;
endpackage

//--- hdl/alu_if.sv
// Carries an operand to the byte unit and its result back.
// Assumes one clock domain; purely combinational path.
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
	import op_pkg::*;
	op_e op;
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] result;
	logic zero;
	modport core (output op, output operand, input result, input zero);
	modport unit (input op, input operand, output result, output zero);
endinterface
`default_nettype wire

//--- hdl/byte_unit.sv
// Byte result unit for invert, decrement and the two clears.
// Assumes the op code is stable while the core samples the result.
`timescale 1ns/100ps
`default_nettype none
module byte_unit
	import op_pkg::*;
(
	alu_if.unit alu
);
	always_comb begin
		case (alu.op)
			OP_INVERT_FILE_REG: alu.result = ~alu.operand;
			OP_FILE_DECREMENT: alu.result = alu.operand - ONE_BYTE;
			default: alu.result = ZERO_BYTE;
		endcase
	end
	assign alu.zero = (alu.result == ZERO_BYTE);
endmodule
`default_nettype wire

//--- hdl/call_clear_core.sv
// Execution block for calls, watchdog kick and byte clear/invert/decrement.
// Assumes the issuer holds start for one cycle and waits for done.
`timescale 1ns/100ps
`default_nettype none
module call_clear_core
	import op_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire op_e op,
	input wire logic [IMM_W-1:0] imm,
	input wire logic [ADDR_W-1:0] file_addr,
	input wire logic dest_sel,
	input wire logic [DATA_W-1:0] file_rdata,
	input wire logic [LATCH_W-1:0] upper_pc_latch,
	output logic [ADDR_W-1:0] file_raddr,
	output logic busy,
	output logic done,
	output logic [PC_W-1:0] pc,
	output logic [PC_W-1:0] stack_head,
	output logic push,
	output logic [DATA_W-1:0] accumulator,
	output logic file_we,
	output logic [ADDR_W-1:0] file_waddr,
	output logic [DATA_W-1:0] file_wdata,
	output logic zero_flag,
	output logic expiry_flag,
	output logic sleep_flag,
	output logic watchdog_clear
);
	// ****************************************************
	// Sequencing
	// ****************************************************
	typedef enum logic {S_IDLE, S_SECOND} state_e;
	state_e state_reg;
	logic [PC_W-1:0] target_reg;
	logic [PC_W-1:0] call_target;
	logic is_call;
	alu_if alu ();

	assign is_call = start && (op == OP_DIRECT_CALL || op == OP_INDIRECT_SUBROUTINE_JUMP);
	assign file_raddr = file_addr;
	assign alu.op = op;
	assign alu.operand = file_rdata;
	assign busy = (state_reg == S_SECOND);

	byte_unit unit_i (.alu(alu));

	always_comb begin
		if (op == OP_DIRECT_CALL)
			call_target = {upper_pc_latch[LATCH_HI:LATCH_LO], imm};
		else
			call_target = {upper_pc_latch, accumulator};
	end

	// Calls hold for a second cycle, so a new start then is ignored
	always_ff @(posedge clock) begin
		if (!rst_n)
			state_reg <= S_IDLE;
		else begin
			case (state_reg)
				S_IDLE: if (is_call) state_reg <= S_SECOND;
				S_SECOND: state_reg <= S_IDLE;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pc <= PC_RESET;
			target_reg <= PC_RESET;
			stack_head <= PC_RESET;
			push <= 1'b0;
			done <= 1'b0;
		end else begin
			push <= 1'b0;
			done <= 1'b0;
			if (state_reg == S_SECOND) begin
				pc <= target_reg;
				done <= 1'b1;
			end else if (start) begin
				if (is_call) begin
					stack_head <= pc + PC_ONE;
					push <= 1'b1;
					target_reg <= call_target;
				end else begin
					pc <= pc + PC_ONE;
					done <= 1'b1;
				end
			end
		end
	end

	// ****************************************************
	// Data path and flags
	// ****************************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			accumulator <= ZERO_BYTE;
			zero_flag <= 1'b0;
			file_we <= 1'b0;
			file_waddr <= '0;
			file_wdata <= ZERO_BYTE;
		end else begin
			file_we <= 1'b0;
			if (start && !busy) begin
				case (op)
					OP_INVERT_FILE_REG, OP_FILE_DECREMENT: begin
						zero_flag <= alu.zero;
						if (dest_sel == DEST_ACC)
							accumulator <= alu.result;
						else begin
							file_we <= 1'b1;
							file_waddr <= file_addr;
							file_wdata <= alu.result;
						end
					end
					OP_ZERO_FILE_REG: begin
						zero_flag <= 1'b1;
						file_we <= 1'b1;
						file_waddr <= file_addr;
						file_wdata <= alu.result;
					end
					OP_ZERO_ACCUMULATOR: begin
						zero_flag <= 1'b1;
						accumulator <= alu.result;
					end
					default: ;
				endcase
			end
		end
	end

	// Flags reset low here; power-on values are the owner's business
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			expiry_flag <= 1'b0;
			sleep_flag <= 1'b0;
			watchdog_clear <= 1'b0;
		end else begin
			watchdog_clear <= start && !busy && op == OP_WATCHDOG_KICK;
			if (start && !busy && op == OP_WATCHDOG_KICK) begin
				expiry_flag <= 1'b1;
				sleep_flag <= 1'b1;
			end
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	sequence call_issue;
		start && !busy && (op == OP_DIRECT_CALL || op == OP_INDIRECT_SUBROUTINE_JUMP);
	endsequence

	sequence call_finish;
		!done ##1 done;
	endsequence

	property call_two_cycles;
		@(posedge clock) disable iff (!rst_n) call_issue |=> call_finish;
	endproperty
	call_length_a: assert property (call_two_cycles) else $error("call not two cycles");

	// Target is checked two edges on, against the operands seen at issue
	direct_target_a: assert property (@(posedge clock) disable iff (!rst_n)
		call_issue and op == OP_DIRECT_CALL |=> ##1 pc == {$past(upper_pc_latch[LATCH_HI:LATCH_LO], 2), $past(imm, 2)})
		else $error("direct call target wrong");

	indirect_target_a: assert property (@(posedge clock) disable iff (!rst_n)
		call_issue and op == OP_INDIRECT_SUBROUTINE_JUMP |=> ##1 pc == {$past(upper_pc_latch, 2), $past(accumulator, 2)})
		else $error("accumulator call target wrong");

	return_push_a: assert property (@(posedge clock) disable iff (!rst_n)
		call_issue |=> push && stack_head == $past(pc) + PC_ONE) else $error("return address wrong");

	call_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
		call_issue |=> $stable(zero_flag) ##1 $stable(zero_flag)) else $error("call changed zero");

	kick_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && op == OP_WATCHDOG_KICK |=> expiry_flag && sleep_flag && watchdog_clear)
		else $error("kick did not set flags");

	decrement_acc_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && op == OP_FILE_DECREMENT && dest_sel == DEST_ACC
		|=> accumulator == $past(file_rdata) - ONE_BYTE && zero_flag == (accumulator == ZERO_BYTE))
		else $error("decrement to accumulator wrong");

	invert_file_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && op == OP_INVERT_FILE_REG && dest_sel != DEST_ACC
		|=> file_we && file_wdata == ~$past(file_rdata) && file_waddr == $past(file_addr))
		else $error("invert to register wrong");

	clear_file_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && op == OP_ZERO_FILE_REG |=> file_we && file_wdata == ZERO_BYTE && zero_flag)
		else $error("register clear wrong");

	clear_acc_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && op == OP_ZERO_ACCUMULATOR |=> accumulator == ZERO_BYTE && zero_flag)
		else $error("accumulator clear wrong");

	invert_acc_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && op == OP_INVERT_FILE_REG && dest_sel == DEST_ACC
		|=> !file_we && accumulator == ~$past(file_rdata) && zero_flag == (accumulator == ZERO_BYTE))
		else $error("invert to accumulator wrong");

	decrement_file_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && op == OP_FILE_DECREMENT && dest_sel != DEST_ACC
		|=> file_we && file_wdata == $past(file_rdata) - ONE_BYTE && zero_flag == ($past(file_rdata) == ONE_BYTE))
		else $error("decrement to register wrong");

	step_advance_a: assert property (@(posedge clock) disable iff (!rst_n)
		start && !busy && !(op == OP_DIRECT_CALL || op == OP_INDIRECT_SUBROUTINE_JUMP)
		|=> done && !push && pc == $past(pc) + PC_ONE)
		else $error("single-cycle step wrong");

	// A start in the second call cycle must leave no trace
	busy_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
		busy |=> !push && !file_we && !watchdog_clear && $stable(accumulator) && $stable(zero_flag))
		else $error("start taken while busy");
endmodule
`default_nettype wire

//--- verif/cpu_call_clear_decrement_ops_test.sv
// Self-checking bench for the call, clear, invert and decrement block.
// Assumes the block sees registered outputs one edge after start.
`timescale 1ns/100ps
`default_nettype none
`define check_eq(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch at %0t got %h exp %h", $time, got, exp); end end
module cpu_call_clear_decrement_ops_test;
	import op_pkg::*;
	logic clock, rst_n = 1'b0, start = 1'b0, dest_sel = 1'b0;
	op_e op = OP_NONE;
	logic [IMM_W-1:0] imm = 11'h000;
	logic [ADDR_W-1:0] file_addr = 7'h00, file_raddr, file_waddr;
	logic [DATA_W-1:0] file_rdata = 8'h00, accumulator, file_wdata;
	logic [LATCH_W-1:0] upper_pc_latch = 7'h00;
	logic [PC_W-1:0] pc, stack_head, exp_pc = PC_RESET;
	logic busy, done, push, file_we, zero_flag, expiry_flag, sleep_flag, watchdog_clear;
	int fail_count = 0, num_checks = 0;
	call_clear_core dut_u (.clock(clock), .rst_n(rst_n), .start(start), .op(op), .imm(imm),
		.file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata),
		.upper_pc_latch(upper_pc_latch), .file_raddr(file_raddr), .busy(busy), .done(done), .pc(pc),
		.stack_head(stack_head), .push(push), .accumulator(accumulator), .file_we(file_we),
		.file_waddr(file_waddr), .file_wdata(file_wdata), .zero_flag(zero_flag),
		.expiry_flag(expiry_flag), .sleep_flag(sleep_flag), .watchdog_clear(watchdog_clear));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ****************************************
	// Scenario tasks
	// ****************************************
	task automatic issue(op_e o, logic [IMM_W-1:0] k, logic [ADDR_W-1:0] a, logic d,
		logic [DATA_W-1:0] rd, logic [LATCH_W-1:0] l);
		@(posedge clock);
		#1;
		start = 1'b1;
		op = o;
		imm = k;
		file_addr = a;
		dest_sel = d;
		file_rdata = rd;
		upper_pc_latch = l;
		@(posedge clock);
		#1;
		start = 1'b0;
	endtask
	// One-cycle operation; the register file contents are held for the whole cycle
	task automatic run1(op_e o, logic [ADDR_W-1:0] a, logic d, logic [DATA_W-1:0] rd,
		logic [DATA_W-1:0] acc, logic we, logic [DATA_W-1:0] wd, logic z);
		issue(o, 11'h000, a, d, rd, 7'h00);
		exp_pc = exp_pc + PC_ONE;
		`check_eq(done, 1'b1)
		`check_eq(pc, exp_pc)
		`check_eq(file_raddr, a)
		`check_eq(accumulator, acc)
		`check_eq(file_we, we)
		`check_eq(zero_flag, z)
		if (we) begin
			`check_eq(file_wdata, wd)
			`check_eq(file_waddr, a)
		end
	endtask
	task automatic t_reset;
		`check_eq(pc, PC_RESET)
		`check_eq({busy, done, zero_flag, expiry_flag, sleep_flag}, 5'h00)
	endtask
	task automatic t_kick;
		run1(OP_WATCHDOG_KICK, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
		`check_eq(watchdog_clear, 1'b1)
		`check_eq({expiry_flag, sleep_flag}, 2'h3)
	endtask
	task automatic t_bytes;
		run1(OP_FILE_DECREMENT, 7'h05, 1'b0, 8'h01, 8'h00, 1'b0, 8'h00, 1'b1);
		run1(OP_INVERT_FILE_REG, 7'h11, 1'b1, 8'hFF, 8'h00, 1'b1, 8'h00, 1'b1);
		run1(OP_FILE_DECREMENT, 7'h22, 1'b1, 8'h00, 8'h00, 1'b1, 8'hFF, 1'b0);
		run1(OP_ZERO_FILE_REG, 7'h7F, 1'b0, 8'h5A, 8'h00, 1'b1, 8'h00, 1'b1);
		run1(OP_INVERT_FILE_REG, 7'h00, 1'b0, 8'h0F, 8'hF0, 1'b0, 8'h00, 1'b0);
		run1(OP_ZERO_ACCUMULATOR, 7'h00, 1'b0, 8'h33, 8'h00, 1'b0, 8'h00, 1'b1);
		run1(OP_INVERT_FILE_REG, 7'h00, 1'b0, 8'h0F, 8'hF0, 1'b0, 8'h00, 1'b0);
		run1(OP_NONE, 7'h00, 1'b0, 8'h00, 8'hF0, 1'b0, 8'h00, 1'b0);
	endtask
	// Both calls: push at the first edge, new counter at the second
	task automatic t_call(op_e o, logic [LATCH_W-1:0] l, logic [PC_W-1:0] target);
		// Start stays high into the busy cycle with a clear, which must be refused
		@(posedge clock);
		#1;
		start = 1'b1;
		op = o;
		imm = 11'h7FF;
		upper_pc_latch = l;
		@(posedge clock);
		#1;
		op = OP_ZERO_ACCUMULATOR;
		`check_eq(push, 1'b1)
		`check_eq(stack_head, exp_pc + PC_ONE)
		`check_eq({busy, done}, 2'h2)
		@(posedge clock);
		#1;
		start = 1'b0;
		`check_eq(pc, target)
		`check_eq({busy, done}, 2'h1)
		@(posedge clock);
		#1;
		`check_eq(done, 1'b0)
		`check_eq(accumulator, 8'hF0)
		`check_eq(zero_flag, 1'b0)
		exp_pc = target;
	endtask
	// ****************************************
	// Main sequence and verdict
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_kick();
		t_bytes();
		t_call(OP_DIRECT_CALL, 7'h55, 15'h57FF);
		t_call(OP_INDIRECT_SUBROUTINE_JUMP, 7'h2B, 15'h2BF0);
		tally_and_finish();
	end
	// Far longer than the roughly 30 cycles the scenarios need
	initial begin
		repeat (2000) @(posedge clock);
		fail_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
